// ---- hdl/tgc_pkg.sv ----
// Purpose: Constants and types for the timer gate control block.
// Assumes: One APB slave on pclk, 32-bit data, one word per register.
// Notes: Bit layout of the gate control register follows the control byte.
// Notes on behaviour
// - With timer running and gate qualify set, the gate decides counting.
// - Gate qualify clear means count on every incrementing edge while the timer runs.
// - Polarity one counts while gate high, zero while gate low.
// - Toggle mode inverts gate flip-flop on each gate rising edge.
// - Toggle mode off holds flip-flop clear and passes gate through.
// - Single-pulse logic controls gate only when single-pulse mode is on.
// - Armed bit set means acquisition waits for edge or pulse is running; software sets it.
// - Armed bit reads zero when idle or done; hardware clears it.
// - Read-only level bit shows effective gate after all processing.
// - Two-bit source select: pin, timer match, comparator one, two.
// - Single pulse counts from next edge after arming, clears on trailing edge.
// - Clearing single-pulse mode also clears the armed bit.
// - Level bit stays valid; falling edge sets event flag even ungated.
// - Stopping the timer clears the gate flip-flop.
package tgc_pkg;
    localparam logic [11:0] ADDR_GATE_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_TIMER_CTRL = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK   = 12'h00C;
    localparam int          BIT_QUALIFY     = 7;
    localparam int          BIT_POLARITY    = 6;
    localparam int          BIT_TOGGLE      = 5;
    localparam int          BIT_SPM         = 4;
    localparam int          BIT_ARMED       = 3;
    localparam int          BIT_LEVEL       = 2;
    localparam int          BIT_SRC_HI      = 1;
    localparam int          BIT_TIMER_RUN   = 0;
    localparam int          BIT_EVT_GATE    = 0;
    localparam logic [1:0]  SRC_PIN         = 2'h0;
    localparam logic [1:0]  SRC_TIMER_MATCH = 2'h1;
    localparam logic [1:0]  SRC_CMP_ONE     = 2'h2;
    localparam logic [1:0]  SRC_CMP_TWO     = 2'h3;

    // Single-pulse acquisition phases.
    typedef enum logic [1:0] {
        SP_IDLE  = 2'b00,
        SP_ARMED = 2'b01,
        SP_PULSE = 2'b10
    } tgc_sp_state_type;

    // Software-writable gate configuration.
    typedef struct packed {
        logic       gate_qualify_en;
        logic       gate_polarity_sel;
        logic       gate_toggle_mode;
        logic       gate_single_pulse_mode;
        logic [1:0] gate_source_sel;
    } tgc_cfg_type;

    // Raw gate candidates.
    typedef struct packed {
        logic gate_pin;
        logic timer_match;
        logic comparator_one_synced_out;
        logic comparator_two_synced_out;
    } tgc_src_type;
endpackage : tgc_pkg

// ---- hdl/tgc_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of asynchronous levels.
// Assumes: Each bit is an independent level; no word coherence needed.
// Notes: The first stage is read only by the second stage.
module tgc_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("tgc_sync needs WIDTH of at least one.");
        end
    end

    // Two stages keep metastability away from the gate logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : tgc_sync

// ---- hdl/tgc_gate.sv ----
// Purpose: Gate control for a 16-bit timer with APB registers and an interrupt.
// Assumes: Gate sources are asynchronous; inc_edge is a pclk-domain strobe.
// Notes: Outputs are registered, so count_enable lags its cause by one cycle.
//
// Our own choices: register access over APB and the register offsets.
module tgc_gate (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire tgc_pkg::tgc_src_type gate_src,
    input  wire logic                inc_edge,
    output logic                     count_enable,
    output logic                     gate_level_now,
    output logic                     timer_run,
    output logic                     irq
);
    import tgc_pkg::*;

    // All state in one record.
    typedef struct packed {
        tgc_cfg_type      cfg;
        logic             timer_run;
        logic             armed;
        tgc_sp_state_type sp;
        logic             toggle_ff;
        logic             raw_prev;
        logic             level;
        logic             level_prev;
        logic             evt;
        logic             mask;
        logic             count_en;
        logic             irq;
        logic [31:0]      rdata;
        logic             ready;
        logic             slverr;
    } tgc_state_type;

    tgc_state_type s_q;
    tgc_state_type s_d;
    tgc_src_type   src_sync;
    logic [3:0]    src_vec;

    assign src_vec = {gate_src.gate_pin, gate_src.timer_match,
                      gate_src.comparator_one_synced_out, gate_src.comparator_two_synced_out};

    // Every gate source is foreign to pclk, so all pass two flops.
    tgc_sync #(
        .WIDTH (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (src_vec),
        .sync_out (src_sync)
    );

    logic gate_raw;
    logic gate_pol;
    logic gate_tog;
    logic gate_eff;
    logic acc;
    logic wr;
    logic rd;
    logic addr_ok;
    logic [7:0] ctrl_rd;

    // Source select, polarity and toggle stage of the gate path.
    always_comb begin
        case (s_q.cfg.gate_source_sel)
            SRC_PIN:         gate_raw = src_sync.gate_pin;
            SRC_TIMER_MATCH: gate_raw = src_sync.timer_match;
            SRC_CMP_ONE:     gate_raw = src_sync.comparator_one_synced_out;
            SRC_CMP_TWO:     gate_raw = src_sync.comparator_two_synced_out;
            default:         gate_raw = 1'b0;
        endcase
        gate_pol = s_q.cfg.gate_polarity_sel ? gate_raw : ~gate_raw;
        gate_tog = s_q.cfg.gate_toggle_mode ? s_q.toggle_ff : gate_pol;
        // Single-pulse mode passes the gate while armed and during the captured pulse.
        // The armed phase must pass it too, so the opening incrementing edge itself counts.
        if (s_q.cfg.gate_single_pulse_mode) begin
            gate_eff = gate_tog && (s_q.sp == SP_ARMED || s_q.sp == SP_PULSE);
        end else begin
            gate_eff = gate_tog;
        end
    end

    // The answer is built in the first access cycle; a write lands when pready is seen high.
    assign acc = psel && penable && !s_q.ready;
    assign wr  = psel && penable && s_q.ready && pwrite;
    assign rd  = acc && !pwrite;
    // Decoding in the first access cycle lets the error answer stand beside pready.
    assign addr_ok = (paddr == ADDR_GATE_CTRL) || (paddr == ADDR_TIMER_CTRL) ||
                     (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK);
    assign ctrl_rd = {s_q.cfg.gate_qualify_en, s_q.cfg.gate_polarity_sel, s_q.cfg.gate_toggle_mode,
                      s_q.cfg.gate_single_pulse_mode, s_q.armed, s_q.level, s_q.cfg.gate_source_sel};

    // Next-state logic for registers, gate stages and the bus answer.
    always_comb begin
        s_d = s_q;
        s_d.raw_prev = gate_pol;
        // Toggle flop flips on the gate rising edge; cleared when off or stopped.
        if (!s_q.cfg.gate_toggle_mode || !s_q.timer_run) begin
            s_d.toggle_ff = 1'b0;
        end else if (gate_pol && !s_q.raw_prev) begin
            s_d.toggle_ff = ~s_q.toggle_ff;
        end
        // Acquisition: armed, pulse opens at next incrementing edge, ends on trailing edge.
        case (s_q.sp)
            SP_IDLE:  s_d.sp = s_q.armed ? SP_ARMED : SP_IDLE;
            SP_ARMED: if (inc_edge && gate_tog) begin
                s_d.sp = SP_PULSE;
            end
            SP_PULSE: if (!gate_tog) begin
                s_d.sp    = SP_IDLE;
                s_d.armed = 1'b0;
            end
            default:  s_d.sp = SP_IDLE;
        endcase
        // The level bit runs even when qualification is off.
        s_d.level      = gate_eff;
        s_d.level_prev = s_q.level;
        // Falling edge of the level sets the sticky flag; the set beats a clear.
        if (wr && paddr == ADDR_IRQ_STATUS && pwdata[BIT_EVT_GATE]) begin
            s_d.evt = 1'b0;
        end
        if (s_q.level_prev && !s_q.level) begin
            s_d.evt = 1'b1;
        end
        s_d.ready  = acc;
        s_d.slverr = acc && !addr_ok;
        s_d.rdata  = '0;
        if (wr) begin
            case (paddr)
                ADDR_GATE_CTRL: begin
                    s_d.cfg.gate_qualify_en        = pwdata[BIT_QUALIFY];
                    s_d.cfg.gate_polarity_sel      = pwdata[BIT_POLARITY];
                    s_d.cfg.gate_toggle_mode       = pwdata[BIT_TOGGLE];
                    s_d.cfg.gate_single_pulse_mode = pwdata[BIT_SPM];
                    s_d.cfg.gate_source_sel        = pwdata[BIT_SRC_HI:0];
                    if (pwdata[BIT_ARMED] && pwdata[BIT_SPM]) begin
                        s_d.armed = 1'b1;
                        s_d.sp    = SP_ARMED;
                    end
                end
                ADDR_TIMER_CTRL: s_d.timer_run = pwdata[BIT_TIMER_RUN];
                ADDR_IRQ_STATUS: ;
                ADDR_IRQ_MASK:   s_d.mask = pwdata[BIT_EVT_GATE];
                default:         ;
            endcase
        end
        if (rd) begin
            case (paddr)
                ADDR_GATE_CTRL:  s_d.rdata = {24'h000000, ctrl_rd};
                ADDR_TIMER_CTRL: s_d.rdata = {31'h00000000, s_q.timer_run};
                ADDR_IRQ_STATUS: s_d.rdata = {31'h00000000, s_q.evt};
                ADDR_IRQ_MASK:   s_d.rdata = {31'h00000000, s_q.mask};
                default:         s_d.rdata = '0;
            endcase
        end
        // Leaving single-pulse mode drops any acquisition.
        if (!s_d.cfg.gate_single_pulse_mode) begin
            s_d.armed = 1'b0;
            s_d.sp    = SP_IDLE;
        end
        // Qualify is ignored while stopped; clear qualify counts freely.
        if (!s_q.timer_run) begin
            s_d.count_en = 1'b0;
        end else if (s_q.cfg.gate_qualify_en) begin
            s_d.count_en = inc_edge && gate_eff;
        end else begin
            s_d.count_en = inc_edge;
        end
        s_d.irq = s_d.evt && s_d.mask;
    end

    // One reset for everything; only power-on style reset is modelled here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata         = s_q.rdata;
    assign pready         = s_q.ready;
    assign pslverr        = s_q.slverr;
    assign count_enable   = s_q.count_en;
    assign gate_level_now = s_q.level;
    assign timer_run      = s_q.timer_run;
    assign irq            = s_q.irq;

    // Checks beside the logic.
    a_stop_no_count: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_run |=> !count_enable) else $error("Counted while stopped.");
    a_free_count: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_run && !s_q.cfg.gate_qualify_en && inc_edge) |=> count_enable) else $error("Missed free count.");
    a_gated_count: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_run && s_q.cfg.gate_qualify_en && inc_edge && !gate_eff) |=> !count_enable)
        else $error("Counted with gate closed.");
    a_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.cfg.gate_toggle_mode || !timer_run) |=> !s_q.toggle_ff) else $error("Toggle flop not cleared.");
    a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.cfg.gate_toggle_mode && timer_run && gate_pol && !s_q.raw_prev) |=> (s_q.toggle_ff != $past(s_q.toggle_ff)))
        else $error("Toggle flop did not flip.");
    a_spm_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cfg.gate_single_pulse_mode |-> !s_q.armed) else $error("Armed without mode.");
    a_level_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> gate_level_now == $past(gate_eff)) else $error("Level bit stale.");
    a_event_set: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.level_prev && !s_q.level) |=> s_q.evt) else $error("Gate event lost.");
    a_pulse_end: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.sp == SP_PULSE && !gate_tog && s_q.cfg.gate_single_pulse_mode && !wr) |=> !s_q.armed)
        else $error("Armed bit not cleared.");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.evt && s_q.mask) |-> irq) else $error("Irq wrong.");

    // Steps of one acquisition, named so the properties read like the timing.
    // A register write in the same cycle may legally override a step, so it is excluded.
    sequence s_arm_write;
        wr && paddr == ADDR_GATE_CTRL && pwdata[BIT_ARMED] && pwdata[BIT_SPM];
    endsequence
    sequence s_pulse_open;
        s_q.sp == SP_ARMED && inc_edge && gate_tog && s_q.cfg.gate_single_pulse_mode && !wr;
    endsequence
    sequence s_pulse_close;
        s_q.sp == SP_PULSE && !gate_tog && s_q.cfg.gate_single_pulse_mode && !wr;
    endsequence

    // Acquisition checks.
    a_arm_sets: assert property (@(posedge pclk) disable iff (!presetn)
        s_arm_write |=> (s_q.armed && s_q.sp == SP_ARMED)) else $error("Arming write lost.");
    a_arm_needs_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_GATE_CTRL && !pwdata[BIT_SPM]) |=> !s_q.armed)
        else $error("Armed without single-pulse mode.");
    a_pulse_opens: assert property (@(posedge pclk) disable iff (!presetn)
        s_pulse_open |=> s_q.sp == SP_PULSE) else $error("Pulse did not open.");
    a_open_counts: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_run && s_q.cfg.gate_qualify_en && s_q.sp == SP_ARMED && inc_edge && gate_tog
         && s_q.cfg.gate_single_pulse_mode) |=> count_enable) else $error("Opening edge not counted.");
    a_pulse_closes: assert property (@(posedge pclk) disable iff (!presetn)
        s_pulse_close |=> (!s_q.armed && s_q.sp == SP_IDLE)) else $error("Pulse did not close.");
    a_idle_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.cfg.gate_single_pulse_mode && s_q.sp == SP_IDLE) |-> !gate_eff)
        else $error("Gate passed after acquisition.");
    a_spm_off_pass: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cfg.gate_single_pulse_mode |-> gate_eff == gate_tog) else $error("Pulse logic leaked.");

    // Source selection checks, one per code, then the polarity check.
    a_source_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.cfg.gate_source_sel == SRC_PIN) |-> gate_raw == src_sync.gate_pin)
        else $error("Pin source not selected.");
    a_source_match: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.cfg.gate_source_sel == SRC_TIMER_MATCH) |-> gate_raw == src_sync.timer_match)
        else $error("Match source not selected.");
    a_source_cmp_one: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.cfg.gate_source_sel == SRC_CMP_ONE) |-> gate_raw == src_sync.comparator_one_synced_out)
        else $error("Comparator one not selected.");
    a_source_cmp_two: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.cfg.gate_source_sel == SRC_CMP_TWO) |-> gate_raw == src_sync.comparator_two_synced_out)
        else $error("Comparator two not selected.");
    a_polarity_sel: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cfg.gate_toggle_mode |-> gate_tog == (s_q.cfg.gate_polarity_sel ? gate_raw : !gate_raw))
        else $error("Polarity not applied.");

    // Bus answer checks: one-cycle ready, error on unmapped words, control byte read back; last, stop clears the flip-flop.
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("Ready held too long.");
    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !addr_ok) |=> pslverr) else $error("Unmapped access not refused.");
    a_ctrl_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && paddr == ADDR_GATE_CTRL) |=> prdata[7:0] == $past(ctrl_rd))
        else $error("Control byte read wrong.");
    a_stop_clears_ff: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(timer_run) |=> !s_q.toggle_ff) else $error("Stop left flip-flop set.");
endmodule : tgc_gate

// ---- tb/tgc_src_model.sv ----
// Purpose: Far-side gate sources: pin, timer match and two comparators.
// Assumes: Levels are asynchronous to pclk; the block resynchronises them.
// Notes: Slow mode lags each request by a cycle, like a sluggish comparator.
module tgc_src_model (
    input  wire logic             pclk,
    input  wire logic             slow,
    input  wire logic [3:0]       lvl_req,
    output tgc_pkg::tgc_src_type  gate_src
);
    import tgc_pkg::*;
    logic [3:0] late_q;
    // Holds the previous request for slow mode.
    always_ff @(posedge pclk) begin
        late_q <= lvl_req;
    end
    // Bit 3 is the pin, then timer match and the two comparators.
    assign gate_src = tgc_src_type'(slow ? late_q : lvl_req);
endmodule : tgc_src_model

// ---- tb/test_timer_gate_control.sv ----
// Purpose: Self-checking bench for the timer gate control block.
// Assumes: APB answers after one wait state.
// Notes: The gate path lag is two sync flops plus the level register.
module test_timer_gate_control;
    timeunit 1ns;
    timeprecision 1ps;
    import tgc_pkg::*;
    localparam int LAG = 5; // Three cycles of lag, one of slow source, one spare.
    logic        pclk, presetn, psel, penable, pwrite, inc_edge, slow;
    logic        pready, pslverr, count_enable, gate_level_now, timer_run, irq, err, seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  lvl_req;
    tgc_src_type gate_src;
    int          miscompares, n_tests;

    tgc_gate uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_src(gate_src), .inc_edge(inc_edge), .count_enable(count_enable),
        .gate_level_now(gate_level_now), .timer_run(timer_run), .irq(irq)
    );
    tgc_src_model model (.pclk(pclk), .slow(slow), .lvl_req(lvl_req), .gate_src(gate_src));

    // A 200 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Every comparison passes through here so the counts stay honest.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits out the gate path lag, then judges the level output.
    task automatic lvl_is(input logic exp);
        repeat (LAG) @(posedge pclk);
        check("gate_level_now", 32'(exp), 32'(gate_level_now));
    endtask : lvl_is

    // One incrementing edge; count_enable is gathered over the next cycles.
    task automatic bump(input logic exp);
        inc_edge <= 1'b1;
        @(posedge pclk);
        inc_edge <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            @(posedge pclk);
            seen = seen | count_enable;
        end
        check("count_enable", 32'(exp), 32'(seen));
    endtask : bump

    // Reset values with the level bit masked, and a refused address.
    task automatic t_reset;
        apb(1'b0, ADDR_GATE_CTRL, 32'h0);
        check("gate_ctrl_reg", 32'h0, rd & 32'hFFFFFFFB);
        apb(1'b0, ADDR_TIMER_CTRL, 32'h0);
        check("timer_run", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        check("pslverr", 32'h1, 32'(err));
    endtask : t_reset

    // Each source under both polarities, the other sources driven opposite.
    task automatic t_source;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                apb(1'b1, ADDR_GATE_CTRL, 32'(s + 64 * p));
                lvl_req <= (4'h8 >> s) ^ {4{p[0]}};
                lvl_is(1'b0);
                lvl_req <= ~lvl_req;
                lvl_is(1'b1);
            end
        end
        apb(1'b0, ADDR_GATE_CTRL, 32'h0);
        check("level bit", 32'h1, 32'(rd[BIT_LEVEL]));
    endtask : t_source

    // Gate closed and open, qualify cleared, then a stopped timer.
    task automatic t_qualify;
        apb(1'b1, ADDR_TIMER_CTRL, 32'h1);
        apb(1'b1, ADDR_GATE_CTRL, 32'hC0);
        lvl_req <= 4'h0;
        lvl_is(1'b0);
        bump(1'b0);
        lvl_req <= 4'h8;
        lvl_is(1'b1);
        bump(1'b1);
        apb(1'b1, ADDR_GATE_CTRL, 32'h40);
        lvl_req <= 4'h0;
        lvl_is(1'b0);
        bump(1'b1);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h0);
        bump(1'b0);
    endtask : t_qualify

    // The flip-flop follows rising edges, clears on stop and when off.
    task automatic t_toggle;
        apb(1'b1, ADDR_TIMER_CTRL, 32'h1);
        apb(1'b1, ADDR_GATE_CTRL, 32'h60);
        lvl_req <= 4'h8;
        lvl_is(1'b1);
        lvl_req <= 4'h0;
        lvl_is(1'b1);
        lvl_req <= 4'h8;
        lvl_is(1'b0);
        lvl_req <= 4'h0;
        lvl_is(1'b0);
        lvl_req <= 4'h8;
        lvl_is(1'b1);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h0);
        lvl_is(1'b0);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h1);
        apb(1'b1, ADDR_GATE_CTRL, 32'h40);
        lvl_is(1'b1);
        lvl_req <= 4'h0;
        lvl_is(1'b0);
    endtask : t_toggle

    // One armed acquisition with a slow source, a rejected second pulse, disarm by mode.
    task automatic t_pulse;
        slow <= 1'b1;
        apb(1'b1, ADDR_GATE_CTRL, 32'hD0);
        lvl_req <= 4'h8;
        repeat (LAG) @(posedge pclk);
        bump(1'b0);
        lvl_req <= 4'h0;
        apb(1'b1, ADDR_GATE_CTRL, 32'hD8);
        apb(1'b0, ADDR_GATE_CTRL, 32'h0);
        check("armed", 32'h1, 32'(rd[BIT_ARMED]));
        lvl_req <= 4'h8;
        repeat (LAG) @(posedge pclk);
        bump(1'b1);
        lvl_req <= 4'h0;
        repeat (LAG) @(posedge pclk);
        apb(1'b0, ADDR_GATE_CTRL, 32'h0);
        check("armed", 32'h0, 32'(rd[BIT_ARMED]));
        lvl_req <= 4'h8;
        repeat (LAG) @(posedge pclk);
        bump(1'b0);
        apb(1'b1, ADDR_GATE_CTRL, 32'hD8);
        apb(1'b1, ADDR_GATE_CTRL, 32'hC0);
        apb(1'b0, ADDR_GATE_CTRL, 32'h0);
        check("armed", 32'h0, 32'(rd[BIT_ARMED]));
        slow <= 1'b0;
    endtask : t_pulse

    // A falling level sets the flag while ungated; unmasked, then masked, cleared each time.
    task automatic t_irq;
        apb(1'b1, ADDR_GATE_CTRL, 32'h40);
        lvl_is(1'b1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        check("irq", 32'h0, 32'(irq));
        for (int m = 1; m >= 0; m--) begin
            apb(1'b1, ADDR_IRQ_MASK, 32'(m));
            lvl_req <= 4'h0;
            lvl_is(1'b0);
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
            check("gate_event_flag", 32'h1, rd);
            check("irq", 32'(m), 32'(irq));
            apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
            check("gate_event_flag", 32'h0, rd);
            check("irq", 32'h0, 32'(irq));
            lvl_req <= 4'h8;
            lvl_is(1'b1);
        end
    endtask : t_irq

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // The whole run needs a few hundred cycles; this cuts a hang short.
    initial begin
        #50us;
        miscompares++;
        wrap_up();
    end

    // Inputs start idle; reset is held for five cycles.
    initial begin
        {presetn, psel, penable, pwrite, inc_edge, slow} = 6'h0;
        {paddr, pwdata, lvl_req} = 48'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_source();
        t_qualify();
        t_toggle();
        t_pulse();
        t_irq();
        wrap_up();
    end
endmodule : test_timer_gate_control
